// >>> logic/ddr_fmt_pkg.sv
// shared constants and carriers of the ddr output formatter
package ddr_fmt_pkg;

    // ************************************************************
    // widths and structure
    // ************************************************************
    localparam int          SAMPLE_W      = 14;
    localparam int          PAIR_N        = 7;
    localparam int          PIPE_STAGES   = 3;
    localparam int          FIFO_DEPTH    = 2;
    localparam int          WORD_W        = SAMPLE_W + 1;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLOCK_MHZ     = 200;
    localparam int          RELOCK_CYCLES = 100;
    localparam logic [6:0]  RELOCK_LAST   = 7'h63;
    localparam logic [1:0]  PHASE_0       = 2'h0;
    localparam logic [1:0]  PHASE_135     = 2'h3;
    localparam int          DUTY_MIN_PCT  = 30;
    localparam int          DUTY_MAX_PCT  = 70;
    localparam int          CNT_W         = 12;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic                  range_exceed;
        logic [SAMPLE_W-1:0]   value;
    } sample_s;

    typedef struct packed {
        logic                  dcs_serial_bit;
        logic                  programming_mode_select;
        logic                  chip_select_level;
        logic [1:0]            phase_step;
        logic                  invert_clock;
    } out_ctrl_s;

    typedef enum logic [2:0] {
        ST_LOCKING = 3'b001,
        ST_LOW     = 3'b010,
        ST_HIGH    = 3'b100
    } tx_state_e;

endpackage : ddr_fmt_pkg

// >>> logic/sample_buffer.sv
// two-entry sample buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sample_buffer
    import ddr_fmt_pkg::*;
(
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // fill side
    input  wire logic       i_in_valid,
    input  wire sample_s    i_in_data,
    output logic            o_in_ready,
    // drain side
    output logic            o_out_valid,
    output sample_s         o_out_data,
    input  wire logic       i_out_ready
);

    sample_s    mem_q [FIFO_DEPTH];
    logic       wr_ptr_q;
    logic       rd_ptr_q;
    logic [1:0] count_q;
    logic       push;
    logic       pop;

    assign push        = i_in_valid && (count_q != 2'h2);
    assign pop         = i_out_ready && (count_q != 2'h0);
    assign o_in_ready  = (count_q != 2'h2);
    assign o_out_valid = (count_q != 2'h0);

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    // read data out of a register so the drain side never sees a mux glitch
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out_data <= '0;
        end else if (count_q == 2'h0 && push) begin
            o_out_data <= i_in_data;
        end else if (pop) begin
            o_out_data <= (count_q == 2'h2) ? mem_q[~rd_ptr_q] : i_in_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule : sample_buffer
`default_nettype wire

// >>> logic/adc_ddr_output_formatter.sv
// ddr output side of a 14-bit sampling converter with duty-cycle stabilizer control
`timescale 1ns/100ps
`default_nettype none
module adc_ddr_output_formatter
    import ddr_fmt_pkg::*;
(
    // clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    // encode clock pin
    input  wire logic                 i_sample_strobe_pos,
    // converter core result
    input  wire sample_s              i_core_sample,
    // control bits
    input  wire out_ctrl_s            i_ctrl,
    // ddr output pins
    output logic [PAIR_N-1:0]         o_ddr_pair,
    output logic                      o_range_exceed_flag_pos,
    output logic                      o_range_exceed_flag_neg,
    output logic                      o_fwd_clock_true,
    output logic                      o_fwd_clock_comp,
    // status
    output logic                      o_dcs_enabled,
    output logic                      o_relocking,
    output logic                      o_sample_dropped
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic        enc_meta_q;
    logic        enc_sync_q;
    logic        enc_prev_q;
    out_ctrl_s   ctrl_meta_q;
    out_ctrl_s   ctrl_sync_q;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enc_meta_q  <= 1'b0;
            enc_sync_q  <= 1'b0;
            enc_prev_q  <= 1'b0;
            ctrl_meta_q <= '0;
            ctrl_sync_q <= '0;
        end else begin
            enc_meta_q  <= i_sample_strobe_pos;
            enc_sync_q  <= enc_meta_q;
            enc_prev_q  <= enc_sync_q;
            ctrl_meta_q <= i_ctrl;
            ctrl_sync_q <= ctrl_meta_q;
        end
    end

    logic enc_rise;
    logic enc_fall;

    assign enc_rise = enc_sync_q && !enc_prev_q;
    assign enc_fall = !enc_sync_q && enc_prev_q;

    // ************************************************************
    // stabilizer enable selection
    // ************************************************************
    logic dcs_en;

    // parallel mode follows the chip-select level, serial mode the register bit
    assign dcs_en = ctrl_sync_q.programming_mode_select
                  ? ctrl_sync_q.chip_select_level
                  : ctrl_sync_q.dcs_serial_bit;

    // ************************************************************
    // encode period tracking and relock
    // ************************************************************
    logic [CNT_W-1:0] period_cnt_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] high_cnt_q;
    logic [6:0]       lock_cnt_q;
    logic             locked_q;
    logic             dcs_en_q;
    logic             freq_change;
    logic             stopped;

    assign freq_change = enc_rise && (period_cnt_q != period_q);
    // an encode clock that has not toggled for a whole counter span counts as stopped
    assign stopped     = (period_cnt_q == '1);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_cnt_q <= '0;
            period_q     <= '0;
            high_cnt_q   <= '0;
        end else begin
            if (enc_rise) begin
                period_cnt_q <= CNT_W'(1);
                period_q     <= period_cnt_q;
            end else if (!stopped) begin
                period_cnt_q <= period_cnt_q + CNT_W'(1);
            end
            if (enc_rise) begin
                high_cnt_q <= CNT_W'(1);
            end else if (enc_sync_q && !stopped) begin
                high_cnt_q <= high_cnt_q + CNT_W'(1);
            end
        end
    end

    // relock: count encode cycles after any disturbance
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_cnt_q <= 7'h00;
            locked_q   <= 1'b0;
            dcs_en_q   <= 1'b0;
        end else begin
            dcs_en_q <= dcs_en;
            if (!dcs_en) begin
                locked_q   <= 1'b1;
                lock_cnt_q <= 7'h00;
            end else if (stopped || freq_change || !dcs_en_q) begin
                locked_q   <= 1'b0;
                lock_cnt_q <= 7'h00;
            end else if (enc_rise && !locked_q) begin
                if (lock_cnt_q == RELOCK_LAST) begin
                    locked_q <= 1'b1;
                end else begin
                    lock_cnt_q <= lock_cnt_q + 7'h01;
                end
            end
        end
    end

    // ************************************************************
    // internal half-cycle mark
    // ************************************************************
    logic [CNT_W-1:0] half_point;
    logic [CNT_W-1:0] quarter;
    logic             mid_edge;

    assign half_point = {1'b0, period_q[CNT_W-1:1]};
    assign quarter    = {2'b00, period_q[CNT_W-1:2]};
    // with stabilizer on the second edge sits mid-period whatever the input duty
    assign mid_edge   = dcs_en ? (period_cnt_q == half_point) : enc_fall;

    // ************************************************************
    // pipeline: sample taken on encode rise
    // ************************************************************
    sample_s pipe_q [PIPE_STAGES];

    genvar g;
    generate
        for (g = 0; g < PIPE_STAGES; g++) begin : g_pipe
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pipe_q[g] <= '0;
                end else if (enc_rise) begin
                    // flag travels in the same word so its latency matches
                    pipe_q[g] <= (g == 0) ? i_core_sample : pipe_q[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    logic    buf_in_ready;
    logic    buf_out_valid;
    sample_s buf_out_data;
    logic    buf_pop;

    sample_buffer u_buffer (
        .i_clock     (i_clock),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (enc_rise && locked_q),
        .i_in_data   (pipe_q[PIPE_STAGES-1]),
        .o_in_ready  (buf_in_ready),
        .o_out_valid (buf_out_valid),
        .o_out_data  (buf_out_data),
        .i_out_ready (buf_pop)
    );

    // ************************************************************
    // ddr transmit state machine
    // ************************************************************
    tx_state_e state_q;
    sample_s   word_q;

    assign buf_pop = enc_rise && (state_q != ST_LOCKING);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_LOCKING;
            word_q  <= '0;
        end else begin
            case (state_q)
                ST_LOCKING: begin
                    if (locked_q && buf_out_valid) begin
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (!locked_q) begin
                        state_q <= ST_LOCKING;
                    end else if (mid_edge) begin
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    // a rise that starts a relock must not open a one-cycle high half
                    if (!locked_q || freq_change) begin
                        state_q <= ST_LOCKING;
                    end else if (enc_rise) begin
                        state_q <= ST_HIGH;
                    end
                end
                default: begin
                    state_q <= ST_LOCKING;
                end
            endcase
            if (buf_pop && buf_out_valid) begin
                word_q <= buf_out_data;
            end
        end
    end

    // ************************************************************
    // output data and flag
    // ************************************************************
    logic [PAIR_N-1:0] pair_q;
    logic              flag_q;

    generate
        for (g = 0; g < PAIR_N; g++) begin : g_pair
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pair_q[g] <= 1'b0;
                end else if (state_q == ST_LOW) begin
                    pair_q[g] <= word_q.value[2*g];
                end else begin
                    pair_q[g] <= word_q.value[2*g+1];
                end
            end
        end
    endgenerate

    // one more stage so data and flag leave on the same edge as the forwarded clock
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_q                  <= 1'b0;
            o_ddr_pair              <= '0;
            o_range_exceed_flag_pos <= 1'b0;
            o_range_exceed_flag_neg <= 1'b1;
        end else begin
            flag_q                  <= word_q.range_exceed;
            o_ddr_pair              <= pair_q;
            o_range_exceed_flag_pos <= flag_q;
            o_range_exceed_flag_neg <= !flag_q;
        end
    end

    // ************************************************************
    // forwarded clock with phase delay
    // ************************************************************
    logic [1:0]       phase_eff;
    logic [CNT_W-1:0] shift_cnt;
    logic [CNT_W-1:0] phase_off;
    logic             base_clk;
    logic             base_prev_q;
    logic             delayed_q;
    logic [CNT_W-1:0] dly_cnt_q;
    logic             pend_q;

    // phase steps only act with the stabilizer on; otherwise zero shift
    assign phase_eff = dcs_en ? ctrl_sync_q.phase_step : PHASE_0;
    // 45 is an eighth of the period, 90 a quarter, 135 a quarter plus an eighth
    assign phase_off = {1'b0, quarter[CNT_W-1:1]};
    assign shift_cnt = (phase_eff[1] ? quarter : '0) + (phase_eff[0] ? phase_off : '0);
    assign base_clk  = (state_q == ST_HIGH);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            base_prev_q <= 1'b0;
            delayed_q   <= 1'b0;
            dly_cnt_q   <= '0;
            pend_q      <= 1'b0;
        end else begin
            base_prev_q <= base_clk;
            if (base_clk != base_prev_q) begin
                if (shift_cnt == '0) begin
                    delayed_q <= base_clk;
                end else begin
                    pend_q    <= 1'b1;
                    dly_cnt_q <= shift_cnt;
                end
            end else if (pend_q) begin
                if (dly_cnt_q == CNT_W'(1)) begin
                    pend_q    <= 1'b0;
                    delayed_q <= base_prev_q;
                end else begin
                    dly_cnt_q <= dly_cnt_q - CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fwd_clock_true <= 1'b0;
            o_fwd_clock_comp <= 1'b1;
            o_dcs_enabled    <= 1'b0;
            o_relocking      <= 1'b1;
            o_sample_dropped <= 1'b0;
        end else begin
            o_fwd_clock_true <= delayed_q ^ ctrl_sync_q.invert_clock;
            o_fwd_clock_comp <= !(delayed_q ^ ctrl_sync_q.invert_clock);
            o_dcs_enabled    <= dcs_en;
            o_relocking      <= !locked_q;
            o_sample_dropped <= enc_rise && locked_q && !buf_in_ready;
        end
    end

endmodule : adc_ddr_output_formatter
`default_nettype wire

// >>> dv/adc_ddr_output_formatter_props.sv
// port assertions of the ddr output formatter
`timescale 1ns/100ps
`default_nettype none
module ddr_fmt_props
    import ddr_fmt_pkg::*;
(
    // clock and reset
    input wire logic              i_clock,
    input wire logic              i_rst_n,
    // inputs
    input wire logic              i_sample_strobe_pos,
    input wire sample_s           i_core_sample,
    input wire out_ctrl_s         i_ctrl,
    // outputs
    input wire logic [PAIR_N-1:0] o_ddr_pair,
    input wire logic              o_range_exceed_flag_pos,
    input wire logic              o_range_exceed_flag_neg,
    input wire logic              o_fwd_clock_true,
    input wire logic              o_fwd_clock_comp,
    input wire logic              o_dcs_enabled,
    input wire logic              o_relocking,
    input wire logic              o_sample_dropped
);
    logic       enc1_q;
    logic       enc2_q;
    logic [7:0] rises_q;

    // ****************
    // encode rises seen while relocking
    // ****************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enc1_q <= 1'h0;
            enc2_q <= 1'h0;
        end else begin
            enc1_q <= i_sample_strobe_pos;
            enc2_q <= enc1_q;
        end
    end

    // saturates so a stopped encode clock cannot wrap it
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n || !o_relocking) begin
            rises_q <= 8'h00;
        end else if (enc1_q && !enc2_q && rises_q != 8'hff) begin
            rises_q <= rises_q + 8'h01;
        end
    end

    // ****************
    // properties
    // ****************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // control levels pass two synchronisers and a register
    sequence ctrl_held;
        $stable(i_ctrl)[*4];
    endsequence

    a_flag_pair: assert property (
        o_range_exceed_flag_pos != o_range_exceed_flag_neg) else $error("flag pair equal");
    a_clock_pair: assert property (
        o_fwd_clock_true != o_fwd_clock_comp) else $error("clock pair equal");
    a_dcs_parallel: assert property (
        ctrl_held ##0 i_ctrl.programming_mode_select
        |-> o_dcs_enabled == i_ctrl.chip_select_level) else $error("parallel enable wrong");
    a_dcs_serial: assert property (
        ctrl_held ##0 !i_ctrl.programming_mode_select
        |-> o_dcs_enabled == i_ctrl.dcs_serial_bit) else $error("serial enable wrong");
    a_relock_start: assert property (
        $rose(o_dcs_enabled) |-> ##[0:2] o_relocking) else $error("no relock on enable");
    a_relock_off: assert property (
        !o_dcs_enabled [*4] |-> !o_relocking) else $error("relock while disabled");
    a_relock_length: assert property (
        $fell(o_relocking) && o_dcs_enabled && $past(o_dcs_enabled)
        |-> rises_q >= 8'h63) else $error("relock too short");
    a_clock_half: assert property (
        $changed(o_fwd_clock_true) && i_ctrl == $past(i_ctrl, 16)
        |=> $stable(o_fwd_clock_true)[*2]) else $error("output clock half too short");
endmodule : ddr_fmt_props

bind adc_ddr_output_formatter ddr_fmt_props u_props (
    .i_clock, .i_rst_n, .i_sample_strobe_pos, .i_core_sample, .i_ctrl, .o_ddr_pair,
    .o_range_exceed_flag_pos, .o_range_exceed_flag_neg, .o_fwd_clock_true,
    .o_fwd_clock_comp, .o_dcs_enabled, .o_relocking, .o_sample_dropped);
`default_nettype wire

// >>> dv/ddr_capture_model.sv
// receiver that rebuilds sample words from the ddr pins
`timescale 1ns/100ps
`default_nettype none
module ddr_capture_model
    import ddr_fmt_pkg::*;
(
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // ddr pins
    input  wire logic [PAIR_N-1:0] i_pair,
    input  wire logic              i_flag,
    input  wire logic              i_fwd,
    input  wire logic              i_relocking,
    // rebuilt words
    output logic                   o_valid,
    output sample_s                o_word
);
    logic              fwd_q;
    logic [PAIR_N-1:0] odd_q;

    // takes the pins where the forwarded clock turns, as a delayed-clock receiver does
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fwd_q   <= 1'h0;
            odd_q   <= '0;
            o_valid <= 1'h0;
            o_word  <= '0;
        end else begin
            fwd_q   <= i_fwd;
            o_valid <= 1'h0;
            if (i_fwd && !fwd_q) begin
                odd_q <= i_pair;
            end
            if (!i_fwd && fwd_q) begin
                for (int g = 0; g < PAIR_N; g++) begin
                    o_word.value[2*g]   <= i_pair[g];
                    o_word.value[2*g+1] <= odd_q[g];
                end
                o_word.range_exceed <= i_flag;
                o_valid             <= !i_relocking;
            end
        end
    end
endmodule : ddr_capture_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench of the ddr output formatter
`timescale 1ns/100ps
`default_nettype none
module tb
    import ddr_fmt_pkg::*;
;
    typedef struct packed {
        logic       mode;
        logic       cs;
        logic       ser;
        logic [1:0] ph;
        logic       dcs;
        logic [3:0] shift;
    } row_s;
    // clock lag grows by phase times 13 cycles over 8, only with the stabilizer on
    localparam row_s ROWS [7] = '{
        '{1'h1, 1'h1, 1'h0, 2'h0, 1'h1, 4'h0}, '{1'h1, 1'h1, 1'h0, 2'h1, 1'h1, 4'h1},
        '{1'h1, 1'h1, 1'h0, 2'h2, 1'h1, 4'h3}, '{1'h1, 1'h1, 1'h0, 2'h3, 1'h1, 4'h4},
        '{1'h0, 1'h0, 1'h1, 2'h3, 1'h1, 4'h4}, '{1'h1, 1'h0, 1'h1, 2'h3, 1'h0, 4'h0},
        '{1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 4'h0}};
    logic              i_clock, i_rst_n, enc, enc_q, enc_run, chk_on, have_prev;
    logic              f_pos, f_neg, ck_t, ck_c, ck_q, dcs, relock, drop, rx_valid;
    logic [PAIR_N-1:0] pair, pair_q;
    logic [6:0]        k, prev_k;
    sample_s           core, rx_word;
    out_ctrl_s         ctrl;
    int                error_cnt, n_checks, n_words, since, lag, lag0, run, hi_len, lo_len, d;
    real               enc_hi, enc_lo;

    adc_ddr_output_formatter dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_sample_strobe_pos(enc), .i_core_sample(core), .i_ctrl(ctrl), .o_ddr_pair(pair),
        .o_range_exceed_flag_pos(f_pos), .o_range_exceed_flag_neg(f_neg),
        .o_fwd_clock_true(ck_t), .o_fwd_clock_comp(ck_c), .o_dcs_enabled(dcs),
        .o_relocking(relock), .o_sample_dropped(drop));
    ddr_capture_model rx (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pair(pair),
        .i_flag(f_pos), .i_fwd(ck_t), .i_relocking(relock), .o_valid(rx_valid),
        .o_word(rx_word));

    // ****************
    // clocks and stream
    // ****************
    initial begin
        i_clock = 1'h0;
        forever #2.5 i_clock = ~i_clock;
    end
    // 15 msps with a 50 percent duty unless a case bends it; edges never meet i_clock
    initial begin
        enc = 1'h0;
        #1.3;
        forever begin
            if (enc_run) begin
                enc = 1'h1;
                #(enc_hi);
                enc = 1'h0;
            end
            #(enc_lo);
        end
    end
    // sample k is {k, ~k} with k[0] as flag, so order, halves and flag show
    always @(posedge i_clock) begin
        enc_q <= enc;
        if (enc && !enc_q) begin
            k    <= k + 7'h01;
            core <= {k[0], k, ~k};
        end
        pair_q <= pair;
        ck_q   <= ck_t;
        since  <= (pair != pair_q) ? 0 : since + 1;
        run    <= (ck_t != ck_q) ? 1 : run + 1;
        if (ck_t && !ck_q) lo_len <= run;
        // the pins always change at a falling edge, not always at a rising one
        if (!ck_t && ck_q) begin
            lag    <= (pair != pair_q) ? 0 : since + 1;
            hi_len <= run;
        end
        if (chk_on) chk(drop, 1'h0);
        if (rx_valid && chk_on) begin
            if (have_prev) chk(rx_word.value[13:7], 7'(prev_k + 7'h01));
            chk(rx_word.value[6:0], 7'(~rx_word.value[13:7]));
            chk(rx_word.range_exceed, rx_word.value[7]);
            prev_k    <= rx_word.value[13:7];
            have_prev <= 1'h1;
            n_words   <= n_words + 1;
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic bail(input logic hung);
        if (hung) begin
            error_cnt++;
            $display("unexpected at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask : bail

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask : cyc

    task automatic reset_chk();
        chk({pair, f_pos, f_neg, ck_t, ck_c, dcs, relock, drop},
            {7'h00, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0});
    endtask : reset_chk

    // waits out a relock, then checks six words in a row
    task automatic stream();
        int w;
        chk_on <= 1'h0;
        for (int j = 0; j < 3000 && relock !== 1'h0; j++) @(posedge i_clock);
        bail(relock !== 1'h0);
        cyc(60);
        have_prev <= 1'h0;
        chk_on    <= 1'h1;
        w = n_words + 6;
        for (int j = 0; j < 400 && n_words < w; j++) @(posedge i_clock);
        bail(n_words < w);
        chk_on <= 1'h0;
    endtask : stream

    // ****************
    // main sequence
    // ****************
    initial begin
        i_rst_n = 1'h0;
        ctrl = '0;
        core = '0;
        k = 7'h00;
        enc_run = 1'h1;
        chk_on = 1'h0;
        have_prev = 1'h0;
        enc_hi = 32.5;
        enc_lo = 32.5;
        cyc(5);
        reset_chk();
        @(posedge i_clock) i_rst_n <= 1'h1;
        for (int r = 0; r < 7; r++) begin
            ctrl <= {ROWS[r].ser, ROWS[r].mode, ROWS[r].cs, ROWS[r].ph, 1'h0};
            cyc(8);
            chk(dcs, ROWS[r].dcs);
            stream();
            if (r == 0) lag0 = lag;
            d = lag - lag0 - int'(ROWS[r].shift);
            chk(d >= -1 && d <= 1, 1'h1);
        end
        // skewed encode duty with the stabilizer on
        ctrl <= {ROWS[0].ser, ROWS[0].mode, ROWS[0].cs, ROWS[0].ph, 1'h0};
        enc_hi = 19.5;
        enc_lo = 45.5;
        cyc(8);
        stream();
        d = hi_len - lo_len;
        chk(d >= -1 && d <= 1, 1'h1);
        // stopped encode, then restart: a full hundred rises of relock
        enc_run = 1'h0;
        enc_hi = 32.5;
        enc_lo = 32.5;
        cyc(4200);
        chk(relock, 1'h1);
        enc_run = 1'h1;
        cyc(1170);
        chk(relock, 1'h1);
        stream();
        // frequency change to 80 ns
        enc_hi = 40.0;
        enc_lo = 40.0;
        cyc(60);
        chk(relock, 1'h1);
        stream();
        // second reset in mid-run
        @(posedge i_clock) i_rst_n <= 1'h0;
        cyc(3);
        reset_chk();
        i_rst_n <= 1'h1;
        cyc(4);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
